//--- core/pgrc_map.vh
/*
 * Register offsets, field positions and reset values of the
 * generator A load/restart control block.
 * Assumes a 4-bit word address and a 16-bit data port.
 */
`ifndef PGRC_MAP_VH
`define PGRC_MAP_VH

// ============================================================
// Register word offsets
`define PGRC_ADDR_ENC        4'h0
`define PGRC_ADDR_FQC        4'h1
`define PGRC_ADDR_MOD        4'h2
`define PGRC_ADDR_VAL0       4'h3
`define PGRC_ADDR_VAL5       4'h8
`define PGRC_ADDR_IRQ_STAT   4'h9
`define PGRC_ADDR_IRQ_MASK   4'ha
`define PGRC_ADDR_CFG        4'hb

// ============================================================
// Enable control fields
`define PGRC_ENC_GEN_EN      7
`define PGRC_ENC_GLD_SEL     6
`define PGRC_ENC_RESTART     2
`define PGRC_ENC_LDOK        1
`define PGRC_ENC_RIE         0

// ============================================================
// Frequency control fields
`define PGRC_FQC_PRSC_HI     2
`define PGRC_FQC_PRSC_LO     1
`define PGRC_FQC_RLD_FLAG    0

// ============================================================
// Configuration fields
`define PGRC_CFG_WP          0
`define PGRC_CFG_MTG         1

// ============================================================
// Interrupt status fields
`define PGRC_IRQ_RELOAD      0
`define PGRC_IRQ_RESTART     1
`define PGRC_IRQ_BITS        2

// ============================================================
// Sizes and reset values
`define PGRC_NUM_VALS        6
`define PGRC_MTG_VALS        2
`define PGRC_DATA_W          16
`define PGRC_MOD_W           15
`define PGRC_PRSC_W          2
`define PGRC_RST_MOD         15'h0000
`define PGRC_RST_PRSC        2'h0
`define PGRC_RST_VAL         16'h0000

`endif

//--- core/pgrc_sync2.v
/*
 * Two flip-flop synchroniser for one level.
 * Assumes the input may change at any time relative to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module pgrc_sync2 (
    // Clock and reset
    input  wire i_clk,
    input  wire i_reset_n,
    // Level in and out
    input  wire i_level,
    output reg  o_level
);

    reg stage1;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage1  <= 1'b0;
            o_level <= 1'b0;
        end else begin
            stage1  <= i_level;
            o_level <= stage1;
        end
    end

endmodule

`default_nettype wire

//--- core/pgrc_value_buf.v
/*
 * Buffered and active pulse-width values, one entry per output.
 * Bus read data come out of a register one cycle after the request.
 * Assumes the caller qualifies i_load and i_load_mask.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pgrc_map.vh"

module pgrc_value_buf (
    // Clock and reset
    input  wire                                      i_clk,
    input  wire                                      i_reset_n,
    // Buffer access
    input  wire                                      i_we,
    input  wire [2:0]                                i_idx,
    input  wire [`PGRC_DATA_W-1:0]                   i_wdata,
    output reg  [`PGRC_DATA_W-1:0]                   o_rdata,
    // Transfer into active set
    input  wire                                      i_load,
    input  wire [`PGRC_NUM_VALS-1:0]                 i_load_mask,
    output wire [`PGRC_NUM_VALS*`PGRC_DATA_W-1:0]    o_active
);

    reg [`PGRC_DATA_W-1:0] buffered [0:`PGRC_NUM_VALS-1];
    reg [`PGRC_DATA_W-1:0] active   [0:`PGRC_NUM_VALS-1];

    genvar g;
    generate
        for (g = 0; g < `PGRC_NUM_VALS; g = g + 1) begin : entry
            always @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    buffered[g] <= `PGRC_RST_VAL;
                    active[g]   <= `PGRC_RST_VAL;
                end else begin
                    if (i_we && (i_idx == g[2:0])) begin
                        buffered[g] <= i_wdata;
                    end
                    if (i_load && i_load_mask[g]) begin
                        active[g] <= buffered[g];
                    end
                end
            end
            assign o_active[g*`PGRC_DATA_W +: `PGRC_DATA_W] = active[g];
        end
    endgenerate

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= `PGRC_RST_VAL;
        end else if (i_idx < `PGRC_NUM_VALS) begin
            o_rdata <= buffered[i_idx];
        end else begin
            o_rdata <= `PGRC_RST_VAL;
        end
    end

endmodule

`default_nettype wire

//--- core/pgrc_ctrl.v
/*
 * Generator A enable, load-okay, restart and reload flag control.
 * Assumes the counter and reload sequencer run on i_clk and give
 * one-cycle pulses; the global load okay comes from another domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pgrc_map.vh"

module pgrc_ctrl (
    // Clock and reset
    input  wire                                   i_clk,
    input  wire                                   i_reset_n,
    // Register port
    input  wire [3:0]                             i_addr,
    input  wire [`PGRC_DATA_W-1:0]                i_wdata,
    input  wire                                   i_wr,
    input  wire                                   i_rd,
    output wire [`PGRC_DATA_W-1:0]                o_rdata,
    // Counter and sequencer side
    input  wire                                   i_cycle_start,
    input  wire                                   i_reload_opportunity,
    input  wire                                   i_commutation,
    input  wire                                   i_global_load_ok,
    output reg                                    o_reload,
    output reg                                    o_restart_a,
    output wire                                   o_generator_a_enable,
    output wire                                   o_multiple_timebase,
    output reg  [`PGRC_PRSC_W-1:0]                o_active_prescaler,
    output reg  [`PGRC_MOD_W-1:0]                 o_active_modulus,
    output wire [`PGRC_NUM_VALS*`PGRC_DATA_W-1:0] o_active_widths,
    // Interrupts
    output wire                                   o_reload_irq,
    output wire                                   o_irq
);

    // ========================================================
    // Control state
    reg                          generator_a_enable;
    reg                          global_load_select_a;
    reg                          restart_on_commutation_a;
    reg                          load_okay_a;
    reg                          reload_irq_enable_a;
    reg                          reload_flag_a;
    reg [`PGRC_PRSC_W-1:0]       prescaler_select_a;
    reg [`PGRC_MOD_W-1:0]        counter_modulus_a;
    reg                          write_protect;
    reg                          multiple_timebase_select;
    reg                          ldok_armed;
    reg                          flag_clear_armed;
    reg                          enable_reload_pending;
    reg [`PGRC_IRQ_BITS-1:0]     irq_status;
    reg [`PGRC_IRQ_BITS-1:0]     irq_mask;
    reg [`PGRC_DATA_W-1:0]       rdata_reg;
    reg                          rd_from_buf;

    wire                         global_ok_sync;
    wire [`PGRC_DATA_W-1:0]      buf_rdata;
    wire                         reload_event;
    wire                         qualifier;
    wire                         transfer;
    wire                         restart_now;
    wire [`PGRC_NUM_VALS-1:0]    width_mask;
    wire [3:0]                   val_off;
    wire                         val_hit;
    wire [7:0]                   enc_read;
    wire [7:0]                   fqc_read;

    // ========================================================
    // Global load okay crossing
    pgrc_sync2 u_gload_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_level   (i_global_load_ok),
        .o_level   (global_ok_sync)
    );

    // ========================================================
    // Decode helpers
    assign val_off = i_addr - `PGRC_ADDR_VAL0;
    assign val_hit = (i_addr >= `PGRC_ADDR_VAL0) &&
                     (i_addr <= `PGRC_ADDR_VAL5);

    assign enc_read = {generator_a_enable, global_load_select_a, 3'h0,
                       restart_on_commutation_a, load_okay_a,
                       reload_irq_enable_a};
    assign fqc_read = {5'h00, prescaler_select_a, reload_flag_a};

    // ========================================================
    // Reload and transfer
    // Enable reload waits for the cycle start
    assign reload_event = i_reload_opportunity |
                          (enable_reload_pending & i_cycle_start);
    assign qualifier    = global_load_select_a ? global_ok_sync
                                               : load_okay_a;
    assign transfer     = reload_event & qualifier;
    assign width_mask   = multiple_timebase_select ?
                          6'h03 : 6'h3f;
    assign restart_now  = i_commutation & restart_on_commutation_a;

    pgrc_value_buf u_values (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_we        (i_wr & val_hit),
        .i_idx       (val_off[2:0]),
        .i_wdata     (i_wdata),
        .o_rdata     (buf_rdata),
        .i_load      (transfer),
        .i_load_mask (width_mask),
        .o_active    (o_active_widths)
    );

    // ========================================================
    // Enable control register
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            generator_a_enable       <= 1'b0;
            global_load_select_a     <= 1'b0;
            restart_on_commutation_a <= 1'b0;
            reload_irq_enable_a      <= 1'b0;
            enable_reload_pending    <= 1'b0;
        end else begin
            if (i_wr && (i_addr == `PGRC_ADDR_ENC)) begin
                generator_a_enable  <= i_wdata[`PGRC_ENC_GEN_EN];
                reload_irq_enable_a <= i_wdata[`PGRC_ENC_RIE];
                if (!write_protect) begin
                    global_load_select_a     <= i_wdata[`PGRC_ENC_GLD_SEL];
                    restart_on_commutation_a <= i_wdata[`PGRC_ENC_RESTART];
                end
            end
            if (i_wr && (i_addr == `PGRC_ADDR_ENC) &&
                i_wdata[`PGRC_ENC_GEN_EN] && !generator_a_enable) begin
                enable_reload_pending <= 1'b1;
            end else if (i_cycle_start) begin
                enable_reload_pending <= 1'b0;
            end
        end
    end

    // ========================================================
    // Load okay handshake
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            load_okay_a <= 1'b0;
            ldok_armed  <= 1'b0;
        end else begin
            if (i_wr && (i_addr == `PGRC_ADDR_ENC)) begin
                if (!i_wdata[`PGRC_ENC_LDOK]) begin
                    load_okay_a <= 1'b0;
                end else if (ldok_armed) begin
                    load_okay_a <= 1'b1;
                end else if (transfer && !global_load_select_a) begin
                    load_okay_a <= 1'b0;
                end
                ldok_armed <= 1'b0;
            end else begin
                if (transfer && !global_load_select_a) begin
                    load_okay_a <= 1'b0;
                end
                if (i_rd && (i_addr == `PGRC_ADDR_ENC) && !load_okay_a) begin
                    ldok_armed <= 1'b1;
                end
            end
        end
    end

    // ========================================================
    // Buffered prescaler and modulus, active copies
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prescaler_select_a <= `PGRC_RST_PRSC;
            counter_modulus_a  <= `PGRC_RST_MOD;
            o_active_prescaler <= `PGRC_RST_PRSC;
            o_active_modulus   <= `PGRC_RST_MOD;
        end else begin
            if (i_wr && (i_addr == `PGRC_ADDR_FQC)) begin
                prescaler_select_a <=
                    i_wdata[`PGRC_FQC_PRSC_HI:`PGRC_FQC_PRSC_LO];
            end
            if (i_wr && (i_addr == `PGRC_ADDR_MOD)) begin
                counter_modulus_a <= i_wdata[`PGRC_MOD_W-1:0];
            end
            if (transfer) begin
                o_active_prescaler <= prescaler_select_a;
                o_active_modulus   <= counter_modulus_a;
            end
        end
    end

    // ========================================================
    // Reload flag, cleared by read-set then write-one
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reload_flag_a    <= 1'b0;
            flag_clear_armed <= 1'b0;
        end else begin
            if (reload_event) begin
                reload_flag_a    <= 1'b1;
                flag_clear_armed <= 1'b0;
            end else if (i_wr && (i_addr == `PGRC_ADDR_FQC)) begin
                if (i_wdata[`PGRC_FQC_RLD_FLAG] && flag_clear_armed) begin
                    reload_flag_a <= 1'b0;
                end
                flag_clear_armed <= 1'b0;
            end else if (i_rd && (i_addr == `PGRC_ADDR_FQC) &&
                         reload_flag_a) begin
                flag_clear_armed <= 1'b1;
            end
        end
    end

    // ========================================================
    // Configuration: write protect is write-once until reset
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            write_protect            <= 1'b0;
            multiple_timebase_select <= 1'b0;
        end else if (i_wr && (i_addr == `PGRC_ADDR_CFG)) begin
            multiple_timebase_select <= i_wdata[`PGRC_CFG_MTG];
            if (i_wdata[`PGRC_CFG_WP]) begin
                write_protect <= 1'b1;
            end
        end
    end

    // ========================================================
    // Restart and reload pulses
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_restart_a <= 1'b0;
            o_reload    <= 1'b0;
        end else begin
            o_restart_a <= restart_now;
            o_reload    <= transfer;
        end
    end

    // ========================================================
    // Interrupt status and mask; a set beats a clear
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_status <= {`PGRC_IRQ_BITS{1'b0}};
            irq_mask   <= {`PGRC_IRQ_BITS{1'b0}};
        end else begin
            if (i_wr && (i_addr == `PGRC_ADDR_IRQ_MASK)) begin
                irq_mask <= i_wdata[`PGRC_IRQ_BITS-1:0];
            end
            irq_status <= (irq_status &
                          ~((i_wr && (i_addr == `PGRC_ADDR_IRQ_STAT)) ?
                            i_wdata[`PGRC_IRQ_BITS-1:0] :
                            {`PGRC_IRQ_BITS{1'b0}})) |
                          {restart_now, reload_event};
        end
    end

    assign o_reload_irq = reload_irq_enable_a & reload_flag_a;
    assign o_irq        = |(irq_status & irq_mask);
    assign o_generator_a_enable = generator_a_enable;
    assign o_multiple_timebase  = multiple_timebase_select;

    // ========================================================
    // Read port, data one cycle after the strobe
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_reg   <= {`PGRC_DATA_W{1'b0}};
            rd_from_buf <= 1'b0;
        end else begin
            rd_from_buf <= i_rd & val_hit;
            if (i_rd) begin
                if (i_addr == `PGRC_ADDR_ENC) begin
                    rdata_reg <= {8'h00, enc_read};
                end else if (i_addr == `PGRC_ADDR_FQC) begin
                    rdata_reg <= {8'h00, fqc_read};
                end else if (i_addr == `PGRC_ADDR_MOD) begin
                    rdata_reg <= {1'b0, counter_modulus_a};
                end else if (i_addr == `PGRC_ADDR_IRQ_STAT) begin
                    rdata_reg <= {14'h0000, irq_status};
                end else if (i_addr == `PGRC_ADDR_IRQ_MASK) begin
                    rdata_reg <= {14'h0000, irq_mask};
                end else if (i_addr == `PGRC_ADDR_CFG) begin
                    rdata_reg <= {14'h0000, multiple_timebase_select,
                                  write_protect};
                end else begin
                    rdata_reg <= {`PGRC_DATA_W{1'b0}};
                end
            end else begin
                rdata_reg <= {`PGRC_DATA_W{1'b0}};
            end
        end
    end

    assign o_rdata = rd_from_buf ? buf_rdata : rdata_reg;

endmodule

`default_nettype wire

//--- sim/pgrc_seq_model.sv
/*
 * Stand-in for the counter, reload sequencer and commutation source.
 * Assumes the bench drives i_run and i_commut_req on i_clk edges.
 */
`timescale 1ns/1ps
`default_nettype none

module pgrc_seq_model #(
    parameter int PERIOD = 16
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // Bench control
    input  wire logic i_run,
    input  wire logic i_commut_req,
    // Sequencer events
    output var  logic o_cycle_start,
    output var  logic o_reload_opportunity,
    output var  logic o_commutation
);
    int unsigned count;

    // ============================================================
    // Cycle counter and one-cycle event pulses
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= 0;
            o_cycle_start <= 1'b0;
            o_reload_opportunity <= 1'b0;
            o_commutation <= 1'b0;
        end else begin
            count <= (count == PERIOD - 1) ? 0 : count + 1;
            o_cycle_start <= (count == 0);
            o_reload_opportunity <= (count == 0) && i_run;
            o_commutation <= i_commut_req && !o_commutation;
        end
    end
endmodule

`default_nettype wire

//--- sim/pgrc_ctrl_asserts.sv
/*
 * Concurrent checks on the generator A load and restart control.
 * Assumes it is bound to the control block, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module pgrc_ctrl_chk (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    // Register port
    input wire logic [3:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    // Sequencer side
    input wire logic        i_cycle_start,
    input wire logic        i_reload_opportunity,
    input wire logic        i_commutation,
    input wire logic        o_reload,
    input wire logic        o_restart_a,
    input wire logic        o_generator_a_enable,
    input wire logic        o_multiple_timebase,
    input wire logic [1:0]  o_active_prescaler,
    input wire logic [14:0] o_active_modulus,
    input wire logic [95:0] o_active_widths,
    // Interrupts
    input wire logic        o_reload_irq,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    // ============================================================
    // Transfers and restarts
    a_restart_cause:
        assert property (o_restart_a |-> $past(i_commutation))
        else $error("restart pulse without commutation");
    a_reload_cause:
        assert property (o_reload |->
            $past(i_reload_opportunity || i_cycle_start))
        else $error("transfer without reload event");
    a_active_hold:
        assert property (!o_reload |->
            $stable(o_active_modulus) && $stable(o_active_prescaler))
        else $error("active period changed outside reload");
    a_widths_hold:
        assert property (!o_reload |-> $stable(o_active_widths))
        else $error("active widths changed outside reload");
    a_mtg_upper:
        assert property ($past(o_multiple_timebase) |->
            $stable(o_active_widths[95:32]))
        else $error("widths two to five moved in multiple timebase");

    // ============================================================
    // Enable and interrupt gating
    a_enable_write:
        assert property ($past(i_wr && i_addr == 4'h0) |->
            o_generator_a_enable == $past(i_wdata[7]))
        else $error("generator enable missed its write");
    a_enable_hold:
        assert property (!$past(i_wr && i_addr == 4'h0) |->
            $stable(o_generator_a_enable))
        else $error("generator enable changed without write");
    a_irq_gate_off:
        assert property (i_wr && i_addr == 4'h0 && !i_wdata[0]
            |=> !o_reload_irq)
        else $error("reload request with enable clear");
    a_irq_rise:
        assert property ($rose(o_reload_irq) |-> $past(i_reload_opportunity
            || i_cycle_start || (i_wr && i_addr == 4'h0)))
        else $error("reload request rose without cause");

    c_restart: cover property (o_restart_a);
    c_reload_mtg: cover property (o_reload && o_multiple_timebase);
    c_irq: cover property ($rose(o_irq));
endmodule

`default_nettype wire

//--- sim/tb.sv
/*
 * Self-checking bench for the generator A load and restart control.
 * Assumes the map header, the sequencer model and the checker.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pgrc_map.vh"

module tb;
    localparam int PER = 16;
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_global_load_ok = 1'b0;
    logic        run = 1'b0;
    logic        creq = 1'b0;
    wire  [15:0] o_rdata;
    wire  [95:0] o_active_widths;
    wire  [14:0] o_active_modulus;
    wire  [1:0]  o_active_prescaler;
    wire         cyc, rop, com, o_reload, o_restart_a, o_reload_irq, o_irq;
    int          failures = 0;
    int          tests_run = 0;
    int          n_rld = 0;
    int          n_rst = 0;

    always #2.5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        if (o_reload === 1'b1) n_rld++;
        if (o_restart_a === 1'b1) n_rst++;
    end

    pgrc_seq_model #(.PERIOD(PER)) u_seq (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_run(run),
        .i_commut_req(creq), .o_cycle_start(cyc),
        .o_reload_opportunity(rop), .o_commutation(com)
    );

    pgrc_ctrl u_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_cycle_start(cyc), .i_reload_opportunity(rop),
        .i_commutation(com), .i_global_load_ok(i_global_load_ok),
        .o_reload(o_reload), .o_restart_a(o_restart_a),
        .o_generator_a_enable(), .o_multiple_timebase(),
        .o_active_prescaler(o_active_prescaler),
        .o_active_modulus(o_active_modulus),
        .o_active_widths(o_active_widths),
        .o_reload_irq(o_reload_irq), .o_irq(o_irq)
    );

    // ============================================================
    // Bus and compare tasks
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(negedge i_clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    // Read of zero arms the load-okay write
    task automatic setok(input logic [15:0] v);
        logic [15:0] d;
        rd(`PGRC_ADDR_ENC, d);
        wr(`PGRC_ADDR_ENC, v);
    endtask

    task automatic wait_rld(input int want);
        int k = n_rld;
        for (int c = 0; c < 2 * PER && n_rld == k; c++) @(negedge i_clk);
        chk(96'(n_rld - k), 96'(want));
    endtask

    task automatic commut(input int want);
        int k = n_rst;
        @(posedge i_clk);
        creq <= 1'b1;
        @(posedge i_clk);
        creq <= 1'b0;
        repeat (4) @(negedge i_clk);
        chk(96'(n_rst - k), 96'(want));
    endtask

    task automatic end_sim;
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ============================================================
    // Test sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rdc(`PGRC_ADDR_ENC, 16'h0000);
        wr(`PGRC_ADDR_ENC, 16'h0001);
        wr(`PGRC_ADDR_ENC, 16'h0003);
        rdc(`PGRC_ADDR_ENC, 16'h0001);
        wr(`PGRC_ADDR_FQC, 16'h0004);
        wr(`PGRC_ADDR_MOD, 16'h1234);
        for (int n = 0; n < 6; n++) wr(4'(`PGRC_ADDR_VAL0 + n), 16'h1100 + 16'(n));
        chk(o_active_modulus, 15'h0000);
        setok(16'h0003);
        run <= 1'b1;
        wait_rld(1);
        run <= 1'b0;
        chk(o_active_prescaler, 2'h2);
        chk(o_active_modulus, 15'h1234);
        for (int n = 0; n < 6; n++) chk(o_active_widths[16*n +: 16], 16'h1100 + 16'(n));
        rdc(`PGRC_ADDR_ENC, 16'h0001);
        chk(o_reload_irq, 1'b1);
        wr(`PGRC_ADDR_ENC, 16'h0000);
        chk(o_reload_irq, 1'b0);
        wr(`PGRC_ADDR_ENC, 16'h0001);
        rdc(`PGRC_ADDR_FQC, 16'h0005);
        wr(`PGRC_ADDR_FQC, 16'h0005);
        chk(o_reload_irq, 1'b0);
        chk(o_irq, 1'b0);
        wr(`PGRC_ADDR_IRQ_MASK, 16'h0001);
        chk(o_irq, 1'b1);
        rdc(`PGRC_ADDR_IRQ_STAT, 16'h0001);
        wr(`PGRC_ADDR_IRQ_STAT, 16'h0001);
        chk(o_irq, 1'b0);
        rdc(4'hc, 16'h0000);
        // Cancelled load with global okay high but not selected
        i_global_load_ok <= 1'b1;
        wr(`PGRC_ADDR_MOD, 16'h0777);
        setok(16'h0003);
        wr(`PGRC_ADDR_ENC, 16'h0001);
        run <= 1'b1;
        wait_rld(0);
        chk(o_active_modulus, 15'h1234);
        i_global_load_ok <= 1'b0;
        wr(`PGRC_ADDR_ENC, 16'h0041);
        wait_rld(0);
        i_global_load_ok <= 1'b1;
        wait_rld(1);
        chk(o_active_modulus, 15'h0777);
        i_global_load_ok <= 1'b0;
        run <= 1'b0;
        wr(`PGRC_ADDR_ENC, 16'h0001);
        // Multiple timebase moves only widths zero and one
        wr(`PGRC_ADDR_CFG, 16'h0002);
        for (int n = 0; n < 6; n++) wr(4'(`PGRC_ADDR_VAL0 + n), 16'h2200 + 16'(n));
        setok(16'h0003);
        run <= 1'b1;
        wait_rld(1);
        run <= 1'b0;
        for (int n = 0; n < 6; n++) chk(o_active_widths[16*n +: 16], (n < 2 ? 16'h2200 : 16'h1100) + 16'(n));
        rdc(`PGRC_ADDR_VAL5, 16'h2205);
        // Restart on commutation, enabled and disabled, restart status unmasked
        wr(`PGRC_ADDR_IRQ_MASK, 16'h0002);
        wr(`PGRC_ADDR_IRQ_STAT, 16'h0003);
        chk(o_irq, 1'b0);
        wr(`PGRC_ADDR_ENC, 16'h0005);
        commut(1);
        chk(o_irq, 1'b1);
        wr(`PGRC_ADDR_ENC, 16'h0001);
        commut(0);
        // Write protect freezes select and restart bits
        wr(`PGRC_ADDR_ENC, 16'h0005);
        wr(`PGRC_ADDR_CFG, 16'h0001);
        wr(`PGRC_ADDR_ENC, 16'h0041);
        rdc(`PGRC_ADDR_ENC, 16'h0005);
        // Enabling the generator forces a reload at cycle start
        wr(`PGRC_ADDR_MOD, 16'h0abc);
        setok(16'h0083);
        wait_rld(1);
        chk(o_active_modulus, 15'h0abc);
        rdc(`PGRC_ADDR_ENC, 16'h0085);
        end_sim;
    end

    initial begin
        #100000;
        failures++;
        end_sim;
    end
endmodule

bind pgrc_ctrl pgrc_ctrl_chk u_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_cycle_start(i_cycle_start),
    .i_reload_opportunity(i_reload_opportunity),
    .i_commutation(i_commutation), .o_reload(o_reload),
    .o_restart_a(o_restart_a),
    .o_generator_a_enable(o_generator_a_enable),
    .o_multiple_timebase(o_multiple_timebase),
    .o_active_prescaler(o_active_prescaler),
    .o_active_modulus(o_active_modulus),
    .o_active_widths(o_active_widths),
    .o_reload_irq(o_reload_irq), .o_irq(o_irq)
);

`default_nettype wire
